/* File: src/wlm_top.sv */
// wake line manager: 16 wake/interrupt lines, shared channel routing, stop entry
// assumes Avalon-MM master in the core clock domain and lines synchronous to CLK
//
// Local design decision: register access over Avalon-MM.
`default_nettype none

module wlm_top (
    input wire logic CLK, // core clock, 20 MHz
    input wire logic RST_N, // async reset, active low
    input wire logic [wlm_pkg::ADDR_W-1:0] ADDRESS, // byte address
    input wire logic READ, // read request
    input wire logic WRITE, // write request
    input wire logic [wlm_pkg::DATA_W-1:0] WRITEDATA, // write data
    output logic [wlm_pkg::DATA_W-1:0] READDATA, // read data
    output logic WAITREQUEST, // high until the answer cycle
    input wire logic [wlm_pkg::LINES-1:0] WAKE_LINES, // external wake lines
    input wire logic DED_IRQ_PIN, // dedicated external irq pin level
    input wire logic EXT_STOP_N, // external stop pin, active low
    input wire logic STOP_ENTERED, // clock unit reports chip stopped
    output logic SHARED_IRQ, // shared external irq channel level
    output logic WAKE_EVENT, // wake request to clock unit
    output logic STOP_REQ, // stop request to clock unit
    output logic STOP_EXIT_FLAG // set on genuine stop exit
);
    typedef struct packed {
        logic mode;
        logic src;
        logic [15:0] mask;
        logic [15:0] pol;
        logic [15:0] pend;
        logic exit_flag;
        logic waitreq;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        logic stopreq;
    } wlm_top_s;

    wlm_top_s s_r, s_nxt;

    logic req;
    logic take;
    logic acc;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] idx;
    logic mapped;
    logic pol_wr;
    logic pend_wr;
    logic [15:0] hit;
    logic stop_bit;
    logic seq_stop_req;
    logic exit_set;
    logic seq_abort;
    logic cond_ok;
    logic wake_hit;
    logic any_active;
    logic any_active_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // one wait cycle per access keeps read data a plain register
    // read data is loaded when the request is first seen, writes commit at the
    // edge where the master sees waitrequest low
    assign req = READ || WRITE;
    assign take = req && s_r.waitreq;
    assign acc = req && !s_r.waitreq;
    assign wr = acc && WRITE;
    assign wdata = WRITEDATA[7:0];
    assign idx = ADDRESS[9:2];
    assign mapped = (ADDRESS[1:0] == 2'h0) && (idx >= wlm_pkg::IDX_STATUS);
    assign pol_wr = wr && mapped
        && (idx == wlm_pkg::IDX_POL_HI || idx == wlm_pkg::IDX_POL_LO);
    assign pend_wr = wr && mapped
        && (idx == wlm_pkg::IDX_PEND_HI || idx == wlm_pkg::IDX_PEND_LO);

    ////////////////////////////////////////////////////////////////////////////
    // line edge detectors

    genvar g;
    generate
        for (g = 0; g < wlm_pkg::LINES; g++) begin : g_line
            wlm_edge u_edge (
                .clk(CLK),
                .rst_n(RST_N),
                .line(WAKE_LINES[g]),
                .polarity(s_r.pol[g]),
                .block(pol_wr),
                .hit(hit[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // stop pattern detector

    assign any_active = |(s_r.pend & s_r.mask);
    assign cond_ok = s_r.mode && !any_active && (|s_r.mask);
    assign wake_hit = |(hit & s_r.mask);

    wlm_stop_seq u_seq (
        .clk(CLK),
        .rst_n(RST_N),
        .ctl_wr(wr && mapped && idx == wlm_pkg::IDX_CTRL),
        .wr_stop(wdata[wlm_pkg::CTRL_STOP_BIT]),
        .other_wr(wr && !(mapped && idx == wlm_pkg::IDX_CTRL)),
        .cond_ok(cond_ok),
        .wake_hit(wake_hit),
        .wake_req(s_r.wake),
        .stop_entered(STOP_ENTERED),
        .stop_req(seq_stop_req),
        .stop_bit(stop_bit),
        .exit_set(exit_set),
        .abort(seq_abort)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register file and outputs

    always_comb begin
        s_nxt = s_r;
        s_nxt.waitreq = !take;
        if (wr && mapped) begin
            unique case (idx)
                wlm_pkg::IDX_STATUS: begin
                    if (!wdata[wlm_pkg::STAT_EXIT_BIT]) begin
                        s_nxt.exit_flag = 1'b0;
                    end
                end
                wlm_pkg::IDX_CTRL: begin
                    s_nxt.mode = wdata[wlm_pkg::CTRL_MODE_BIT];
                    s_nxt.src = wdata[wlm_pkg::CTRL_SRC_BIT];
                end
                wlm_pkg::IDX_MASK_HI: s_nxt.mask[15:8] = wdata;
                wlm_pkg::IDX_MASK_LO: s_nxt.mask[7:0] = wdata;
                wlm_pkg::IDX_POL_HI: s_nxt.pol[15:8] = wdata;
                wlm_pkg::IDX_POL_LO: s_nxt.pol[7:0] = wdata;
                wlm_pkg::IDX_PEND_HI: s_nxt.pend[15:8] = wdata;
                wlm_pkg::IDX_PEND_LO: s_nxt.pend[7:0] = wdata;
                default: begin
                end
            endcase
        end
        // a fresh edge wins over a software clear in the same cycle
        s_nxt.pend = s_nxt.pend | hit;
        if (seq_abort) begin
            s_nxt.exit_flag = 1'b0;
        end
        if (exit_set) begin
            s_nxt.exit_flag = 1'b1;
        end
        s_nxt.rdata = wlm_pkg::RST_BYTE;
        if (take && READ && mapped) begin
            unique case (idx)
                wlm_pkg::IDX_STATUS: s_nxt.rdata = {7'h00, s_r.exit_flag};
                wlm_pkg::IDX_CTRL: s_nxt.rdata = {5'h00, stop_bit, s_r.src, s_r.mode};
                wlm_pkg::IDX_MASK_HI: s_nxt.rdata = s_r.mask[15:8];
                wlm_pkg::IDX_MASK_LO: s_nxt.rdata = s_r.mask[7:0];
                wlm_pkg::IDX_POL_HI: s_nxt.rdata = s_r.pol[15:8];
                wlm_pkg::IDX_POL_LO: s_nxt.rdata = s_r.pol[7:0];
                wlm_pkg::IDX_PEND_HI: s_nxt.rdata = s_r.pend[15:8];
                wlm_pkg::IDX_PEND_LO: s_nxt.rdata = s_r.pend[7:0];
                default: s_nxt.rdata = wlm_pkg::RST_BYTE;
            endcase
        end
        // channel drops for one cycle on a pending write so a rising edge reappears
        s_nxt.irq = s_nxt.src ? (any_active_nxt && !pend_wr) : DED_IRQ_PIN;
        s_nxt.wake = s_nxt.mode && any_active_nxt;
        s_nxt.stopreq = seq_stop_req || !EXT_STOP_N;
    end

    assign any_active_nxt = |(s_nxt.pend & s_nxt.mask);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '{mode: 1'b0, src: 1'b0, mask: wlm_pkg::RST_LINES,
                pol: wlm_pkg::RST_LINES, pend: wlm_pkg::RST_LINES, exit_flag: 1'b0,
                waitreq: 1'b1, rdata: wlm_pkg::RST_BYTE, irq: 1'b0, wake: 1'b0,
                stopreq: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign READDATA = {24'h00_0000, s_r.rdata};
    assign WAITREQUEST = s_r.waitreq;
    assign SHARED_IRQ = s_r.irq;
    assign WAKE_EVENT = s_r.wake;
    assign STOP_REQ = s_r.stopreq;
    assign STOP_EXIT_FLAG = s_r.exit_flag;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    bus_answer_a: assert property (req && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    stop_pin_a: assert property (!EXT_STOP_N |=> STOP_REQ)
        else $error("stop pin did not request stop");
    wake_mask_a: assert property (WAKE_EVENT |-> s_r.mode && |(s_r.pend & s_r.mask))
        else $error("wake event without unmasked pending");
    wake_gate_a: assert property (s_nxt.mode && any_active_nxt |=> WAKE_EVENT)
        else $error("wake event missing");
    pin_route_a: assert property (!s_nxt.src |=> SHARED_IRQ == $past(DED_IRQ_PIN))
        else $error("dedicated pin not routed");
    irq_reedge_a: assert property (s_r.src && pend_wr && any_active_nxt && s_nxt.src
        |=> !SHARED_IRQ ##1 (SHARED_IRQ || !s_r.src || !any_active))
        else $error("pending clear gave no new edge");
    pend_set_a: assert property (hit[0] |=> s_r.pend[0])
        else $error("edge did not set pending");
    exit_keep_a: assert property (exit_set |-> ##1 STOP_EXIT_FLAG)
        else $error("exit flag not set on stop exit");
endmodule

`default_nettype wire

/* File: src/wlm_pkg.sv */
// package of constants for the wake line manager block
// assumes a 20 MHz core clock and a byte-addressed Avalon-MM register port
//
// Function
// - write 1,0,1 to stop bit requests stop
// - accept only in wake mode, clean, masked-in
// - any other write aborts; both bits read 0
// - stop reads 1 after first and third write
// - wake event while stopped clears stop bit
// - stop request ORed with active-low stop pin
// - one unmasked line event ends stop mode
// - event during pattern cancels stop, pending kept
// - source select picks pin or 16 lines
// - mode bit enables wake use; channel routing ignores it
// - mask and pending drive channel and wake
// - masked line never produces wake event
// - pending clear re-creates channel rising edge
// - pending bits edge sensitive, clearable while active
// - genuine exit keeps exit flag until cleared
// - polarity 0 falling edge, 1 rising edge
// - edge sets pending; software clears or sets
// - edge during polarity write is lost
`default_nettype none

package wlm_pkg;
    localparam int LINES = 16;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'hF8;
    localparam logic [7:0] IDX_CTRL = 8'hF9;
    localparam logic [7:0] IDX_MASK_HI = 8'hFA;
    localparam logic [7:0] IDX_MASK_LO = 8'hFB;
    localparam logic [7:0] IDX_POL_HI = 8'hFC;
    localparam logic [7:0] IDX_POL_LO = 8'hFD;
    localparam logic [7:0] IDX_PEND_HI = 8'hFE;
    localparam logic [7:0] IDX_PEND_LO = 8'hFF;
    // wakeup_control fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    // status register field
    localparam int STAT_EXIT_BIT = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [15:0] RST_LINES = 16'h0000;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_GOT1 = 4'h2,
        SEQ_GOT0 = 4'h4,
        SEQ_ARMED = 4'h8
    } wlm_seq_e;
endpackage

`default_nettype wire

/* File: src/wlm_edge.sv */
// one wake line edge detector with selectable polarity
// assumes the line is synchronous to clk
`default_nettype none

module wlm_edge (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic line, // wake line level
    input wire logic polarity, // 1 rising, 0 falling
    input wire logic block, // polarity register being written
    output logic hit // one-cycle edge event
);
    typedef struct packed {
        logic prev;
    } wlm_edge_s;

    wlm_edge_s s_r, s_nxt;

    always_comb begin
        s_nxt.prev = line;
    end

    // a write to the polarity registers swallows the edge
    assign hit = !block && (polarity ? (line && !s_r.prev) : (!line && s_r.prev));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rise_hit_a: assert property (polarity && !block && $rose(line) |-> hit)
        else $error("rising edge missed");
    block_hit_a: assert property (block |-> !hit)
        else $error("edge seen during polarity write");
endmodule

`default_nettype wire

/* File: src/wlm_stop_seq.sv */
// stop bit pattern detector and stop/exit tracking
// assumes write strobes are one-cycle pulses of accepted bus writes
`default_nettype none

module wlm_stop_seq (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic ctl_wr, // accepted write to wakeup_control
    input wire logic wr_stop, // stop bit value in that write
    input wire logic other_wr, // accepted write elsewhere
    input wire logic cond_ok, // stop entry conditions hold
    input wire logic wake_hit, // new edge on an unmasked line
    input wire logic wake_req, // wake event level
    input wire logic stop_entered, // clock unit reports chip stopped
    output logic stop_req, // stop request, armed state only
    output logic stop_bit, // stop bit value
    output logic exit_set, // pulse: genuine stop exit
    output logic abort // pulse: pattern or entry cancelled
);
    typedef struct packed {
        wlm_pkg::wlm_seq_e st;
        logic stop;
        logic dead;
        logic exit;
        logic abort;
    } wlm_seq_s;

    wlm_seq_s s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.exit = 1'b0;
        s_nxt.abort = 1'b0;
        unique case (s_r.st)
            wlm_pkg::SEQ_IDLE: begin
                if (ctl_wr && wr_stop) begin
                    s_nxt.st = wlm_pkg::SEQ_GOT1;
                    s_nxt.stop = 1'b1;
                end else if (ctl_wr) begin
                    s_nxt.stop = 1'b0;
                end
            end
            wlm_pkg::SEQ_GOT1: begin
                if (wake_hit || other_wr) begin
                    s_nxt.abort = 1'b1;
                end else if (ctl_wr && !wr_stop) begin
                    s_nxt.st = wlm_pkg::SEQ_GOT0;
                    s_nxt.stop = 1'b0;
                end else if (ctl_wr) begin
                    s_nxt.stop = 1'b1;
                    s_nxt.dead = 1'b0;
                end
            end
            wlm_pkg::SEQ_GOT0: begin
                if (wake_hit || other_wr) begin
                    s_nxt.abort = 1'b1;
                end else if (ctl_wr && wr_stop && cond_ok && !s_r.dead) begin
                    s_nxt.st = wlm_pkg::SEQ_ARMED;
                    s_nxt.stop = 1'b1;
                end else if (ctl_wr) begin
                    s_nxt.st = wlm_pkg::SEQ_IDLE;
                    s_nxt.stop = 1'b0;
                    s_nxt.dead = 1'b0;
                end
            end
            wlm_pkg::SEQ_ARMED: begin
                if (stop_entered) begin
                    if (wake_req) begin
                        s_nxt.exit = 1'b1;
                        s_nxt.st = wlm_pkg::SEQ_IDLE;
                        s_nxt.stop = 1'b0;
                    end
                end else if (ctl_wr || other_wr || wake_req) begin
                    s_nxt.abort = 1'b1;
                end
            end
            default: begin
                s_nxt.abort = 1'b1;
            end
        endcase
        if (s_nxt.abort) begin
            s_nxt.stop = 1'b0;
            if (s_r.st == wlm_pkg::SEQ_GOT1 || s_r.st == wlm_pkg::SEQ_GOT0) begin
                // a broken pattern keeps its place so its last write cannot read back 1
                s_nxt.dead = 1'b1;
            end else begin
                s_nxt.st = wlm_pkg::SEQ_IDLE;
                s_nxt.dead = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: wlm_pkg::SEQ_IDLE, stop: 1'b0, dead: 1'b0, exit: 1'b0, abort: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // the bit reads 1 after a first write too, but only the armed state asks for stop
    assign stop_req = (s_r.st == wlm_pkg::SEQ_ARMED);
    assign stop_bit = s_r.stop;
    assign exit_set = s_r.exit;
    assign abort = s_r.abort;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence pat_1_0;
        (ctl_wr && wr_stop && s_r.st == wlm_pkg::SEQ_IDLE)
            ##[1:20] (ctl_wr && !wr_stop && s_r.st == wlm_pkg::SEQ_GOT1 && !wake_hit);
    endsequence

    zero_step_a: assert property (pat_1_0 |=> s_r.st == wlm_pkg::SEQ_GOT0 && !stop_bit)
        else $error("second pattern write not taken");
    stop_accept_a: assert property (s_r.st == wlm_pkg::SEQ_GOT0 && ctl_wr && wr_stop
        && cond_ok && !s_r.dead && !other_wr && !wake_hit |=> stop_bit)
        else $error("good pattern did not set stop");
    cond_fail_a: assert property (s_r.st == wlm_pkg::SEQ_GOT0 && ctl_wr && !cond_ok
        |=> !stop_bit)
        else $error("stop set without conditions");
    abort_clear_a: assert property ((s_r.st == wlm_pkg::SEQ_GOT1) && other_wr
        |=> !stop_bit && abort && s_r.dead && s_r.st == wlm_pkg::SEQ_GOT1)
        else $error("intervening write did not abort");
    first_one_a: assert property (ctl_wr && wr_stop && s_r.st == wlm_pkg::SEQ_IDLE
        |=> stop_bit)
        else $error("first write did not store 1");
    exit_clear_a: assert property (s_r.st == wlm_pkg::SEQ_ARMED && stop_entered && wake_req
        |=> !stop_bit && exit_set)
        else $error("wake did not clear stop");
endmodule

`default_nettype wire

/* File: dv/wlm_clk_unit.sv */
// clock unit model: stops the chip on request, restarts after a delay
// assumes stop and wake requests come from the wake line manager on the same clock
`default_nettype none

module wlm_clk_unit #(
    parameter int ENTRY_DLY = 12,
    parameter int RESTART_DLY = 8
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic stop_req, // stop request
    input wire logic wake_event, // wake request
    output logic stopped // high while chip is stopped
);
    timeunit 1ns;
    timeprecision 1ns;

    int cnt;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stopped <= 1'b0;
            cnt <= 0;
        end else if (!stopped) begin
            // entry takes several cycles, a dropped request cancels it
            cnt <= stop_req ? cnt + 1 : 0;
            if (stop_req && cnt == ENTRY_DLY - 1) begin
                stopped <= 1'b1;
                cnt <= 0;
            end
        end else if (!stop_req || wake_event) begin
            // oscillator restart delay before the clock runs again
            cnt <= cnt + 1;
            if (cnt == RESTART_DLY - 1) begin
                stopped <= 1'b0;
                cnt <= 0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
// testbench for the wake line manager: register tests over Avalon-MM
// assumes the clock unit model on the stop side and the bench driving the lines
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] MODE = 8'(1 << wlm_pkg::CTRL_MODE_BIT);
    localparam logic [7:0] SRC = 8'(1 << wlm_pkg::CTRL_SRC_BIT);
    localparam logic [7:0] STP = 8'(1 << wlm_pkg::CTRL_STOP_BIT);
    localparam logic [7:0] CT = wlm_pkg::IDX_CTRL;
    localparam logic [7:0] ST = wlm_pkg::IDX_STATUS;
    localparam logic [7:0] ML = wlm_pkg::IDX_MASK_LO;
    localparam logic [7:0] PL = wlm_pkg::IDX_PEND_LO;

    logic clk, rst_n, rd_en, wr_en, ded_pin, ext_stop_n, stopped, seen_low;
    logic waitreq, shared_irq, wake_ev, stop_req, exit_flag;
    logic [9:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] lines;
    logic [7:0] fb [3] = '{MODE, 8'h00, MODE};
    logic [7:0] fm [3] = '{8'h03, 8'h01, 8'h00};
    logic [7:0] fp [3] = '{8'h02, 8'h00, 8'h02};
    int error_cnt = 0;
    int n_compared = 0;

    wlm_top i_dut (.CLK(clk), .RST_N(rst_n), .ADDRESS(addr), .READ(rd_en), .WRITE(wr_en),
        .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq), .WAKE_LINES(lines),
        .DED_IRQ_PIN(ded_pin), .EXT_STOP_N(ext_stop_n), .STOP_ENTERED(stopped),
        .SHARED_IRQ(shared_irq), .WAKE_EVENT(wake_ev), .STOP_REQ(stop_req),
        .STOP_EXIT_FLAG(exit_flag));

    wlm_clk_unit i_clk_unit (.clk(clk), .rst_n(rst_n), .stop_req(stop_req),
        .wake_event(wake_ev), .stopped(stopped));

    ////////////////////////////////////////////////////////////////////////
    task automatic fail(input string what);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, what);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", what, got, exp));
        end
    endtask

    task automatic final_report;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (n >= 20) fail("no bus answer");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h00_0000, exp}, $sformatf("reg %h", idx));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic setl(input logic [15:0] v);
        @(posedge clk);
        lines <= v;
    endtask

    task automatic wait_stop(input logic want);
        int n;
        n = 0;
        while (stopped !== want && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n >= 60) fail("stop state not reached");
    endtask

    task automatic pat(input logic [7:0] b, input logic mid);
        wr(CT, b | STP);
        if (mid) rc(CT, b | STP);
        wr(CT, b);
        if (mid) rc(CT, b);
        wr(CT, b | STP);
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(20_000 * 50);
        fail("watchdog expired");
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 10'h000;
        wdata = 32'h0000_0000;
        lines = 16'h0002;
        ded_pin = 1'b0;
        ext_stop_n = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 8; i < 16; i++) rc(8'hF0 + 8'(i), 8'h00);
        wr(8'h10, 8'hFF);
        rc(8'h10, 8'h00);
        wr(wlm_pkg::IDX_MASK_HI, 8'hA5);
        rc(wlm_pkg::IDX_MASK_HI, 8'hA5);
        wr(wlm_pkg::IDX_MASK_HI, 8'h00);
        // line 0 rises on rising polarity, line 1 falls on falling polarity
        wr(wlm_pkg::IDX_POL_LO, 8'h01);
        setl(16'h0001);
        cyc(2);
        rc(PL, 8'h03);
        wr(PL, 8'h00);
        rc(PL, 8'h00);
        wr(wlm_pkg::IDX_PEND_HI, 8'h80);
        rc(wlm_pkg::IDX_PEND_HI, 8'h80);
        wr(wlm_pkg::IDX_PEND_HI, 8'h00);
        // routing of one pending line over every mask, source and mode
        wr(PL, 8'h01);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            ded_pin <= k[0] ^ k[2];
            wr(ML, {7'h00, k[2]});
            wr(CT, {6'h00, k[1:0]});
            cyc(3);
            chk(32'(shared_irq), 32'(k[1] ? k[2] : k[0] ^ k[2]), "shared");
            chk(32'(wake_ev), 32'(k[0] & k[2]), "wake");
        end
        // clearing one of two pending bits re-creates a rising edge
        wr(ML, 8'h03);
        wr(CT, SRC);
        wr(PL, 8'h03);
        cyc(3);
        seen_low = 1'b0;
        wr(PL, 8'h02);
        repeat (4) begin
            @(posedge clk);
            if (shared_irq === 1'b0) seen_low = 1'b1;
        end
        chk(32'(seen_low), 32'h0000_0001, "no low gap");
        chk(32'(shared_irq), 32'h0000_0001, "no re-rise");
        // pattern refused when mode, pending or mask conditions fail
        for (int k = 0; k < 3; k++) begin
            wr(ML, fm[k]);
            wr(PL, fp[k]);
            pat(fb[k], 1'b0);
            cyc(6);
            rc(CT, fb[k]);
            chk(32'(stop_req), 32'h0000_0000, "refused stop");
        end
        setl(16'h0000);
        wr(ML, 8'h01);
        wr(PL, 8'h00);
        // intervening write aborts and the detector keeps its place, so the last write reads 0
        wr(CT, MODE | STP);
        wr(wlm_pkg::IDX_MASK_HI, 8'h00);
        wr(CT, MODE);
        wr(CT, MODE | STP);
        cyc(3);
        rc(CT, MODE);
        rc(ST, 8'h00);
        // line event inside the pattern cancels it, pending kept
        wr(CT, MODE | STP);
        setl(16'h0001);
        wr(CT, MODE);
        wr(CT, MODE | STP);
        cyc(3);
        rc(CT, MODE);
        rc(ST, 8'h00);
        rc(PL, 8'h01);
        setl(16'h0000);
        wr(PL, 8'h00);
        // genuine stop, wake by line 0, exit flag kept until cleared
        pat(MODE, 1'b1);
        chk(32'(stop_req), 32'h0000_0001, "stop request");
        wait_stop(1'b1);
        rc(CT, MODE | STP);
        setl(16'h0001);
        wait_stop(1'b0);
        rc(CT, MODE);
        rc(ST, 8'h01);
        chk(32'(exit_flag), 32'h0000_0001, "exit flag");
        wr(ST, 8'h00);
        rc(ST, 8'h00);
        rc(PL, 8'h01);
        wr(PL, 8'h00);
        // external stop pin requests stop without the stop bit
        @(posedge clk);
        ext_stop_n <= 1'b0;
        cyc(3);
        chk(32'(stop_req), 32'h0000_0001, "pin stop");
        @(posedge clk);
        ext_stop_n <= 1'b1;
        wait_stop(1'b0);
        final_report();
    end
endmodule

`default_nettype wire
